//--- hdl/wdt_pkg.sv
// package: constants and types for the write-once watchdog
package wdt_pkg;
    localparam logic [7:0] WDT_MODE_RESET   = 8'h67;
    localparam logic [7:0] WDT_KEY_RESET    = 8'h9A;
    localparam logic [7:0] WDT_KEY_VALUE    = 8'hAC;
    localparam logic [7:0] WDT_MODE_STOPPED = 8'h1F;
    localparam logic [4:0] WDT_SEL_STOP     = 5'h1F;
    localparam int         WDT_SEL_LSB      = 0;
    localparam int         WDT_SEL_MSB      = 4;
    localparam int         WDT_MODE_LO_BIT  = 5;
    localparam int         WDT_MODE_HI_BIT  = 6;
    localparam int         WDT_SRC_BIT      = 3;
    localparam int         WDT_OSC_EXP_BASE = 12;
    localparam int         WDT_PER_EXP_BASE = 16;
    localparam int         WDT_CNT_W        = 24;
    // APB map of the controller's own registers
    localparam logic [7:0] WDT_APB_MODE     = 8'h00;
    localparam logic [7:0] WDT_APB_KEY      = 8'h04;
    localparam logic [7:0] WDT_APB_STATUS   = 8'h08;
    localparam logic [7:0] WDT_APB_CMD      = 8'h0C;
    localparam int         WDT_CMD_MODE_WR  = 0;
    localparam int         WDT_CMD_KEY_WR   = 1;
    localparam int         WDT_CMD_MODE_RD  = 2;
    localparam int         WDT_CMD_KEY_RD   = 3;
    typedef enum logic [2:0] {
        WDT_H_IDLE = 3'b001,
        WDT_H_ACC  = 3'b010,
        WDT_H_DONE = 3'b100
    } wdt_host_state_t;
endpackage

//--- hdl/wdt_if.sv
// interface: byte register port between the processor side and the watchdog
`timescale 1ns/10ps
interface wdt_if;
    logic       wr_mode;
    logic       wr_key;
    logic       rd_mode;
    logic       rd_key;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       reset_out;
    logic       nmi_request;
    logic       cpu_on_osc;
    modport device (input wr_mode, input wr_key, input rd_mode, input rd_key,
                    input wdata, output rdata, output reset_out,
                    output nmi_request, output cpu_on_osc);
    modport host (output wr_mode, output wr_key, output rd_mode, output rd_key,
                  output wdata, input rdata, input reset_out,
                  input nmi_request, input cpu_on_osc);
endinterface

//--- hdl/wdt_tick_sel.sv
// rate selector: turns the two source ticks into one count enable
`timescale 1ns/10ps
module wdt_tick_sel (
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    input  wire logic i_osc_tick,
    input  wire logic i_per_tick,
    input  wire logic i_use_per,
    output logic      o_tick
);
    import wdt_pkg::*;
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_tick <= 1'b0;
        end else begin
            o_tick <= i_use_per ? i_per_tick : i_osc_tick;
        end
    end
endmodule

//--- hdl/wdt_device.sv
// watchdog end: write-once mode register, restart key, overflow actions
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/10ps
module wdt_device (
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    input  wire logic i_osc_tick,
    input  wire logic i_per_tick,
    input  wire logic i_option_clock_lock,
    input  wire logic i_osc_stabilizing,
    wdt_if.device     bus
);
    import wdt_pkg::*;

    logic [7:0]           mode_reg;
    logic                 written_reg;
    logic [7:0]           key_reg;
    logic [WDT_CNT_W-1:0] count_reg;
    logic                 reset_reg;
    logic                 nmi_reg;
    logic                 osc_sw_reg;
    logic [7:0]           rdata_reg;
    logic                 lock_q1;
    logic                 lock_reg;
    logic                 stab_q1;
    logic                 stab_q2;
    logic [4:0]           sel;
    logic                 use_per;
    logic                 stopped;
    logic                 tick;
    logic [4:0]           exp_bits;
    logic                 overflow;

    // strap comes from outside the clock domain: two flops before use
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            lock_q1  <= 1'b0;
            lock_reg <= 1'b0;
        end else begin
            lock_q1  <= i_option_clock_lock;
            lock_reg <= lock_q1;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            stab_q1 <= 1'b0;
            stab_q2 <= 1'b0;
        end else begin
            stab_q1 <= i_osc_stabilizing;
            stab_q2 <= stab_q1;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_reg    <= WDT_MODE_RESET;
            written_reg <= 1'b0;
        end else if (bus.wr_mode && !written_reg) begin
            mode_reg    <= bus.wdata;
            written_reg <= 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            key_reg <= WDT_KEY_RESET;
        end else if (bus.wr_key) begin
            key_reg <= bus.wdata;
        end
    end

    assign sel     = mode_reg[WDT_SEL_MSB:WDT_SEL_LSB];
    assign stopped = (sel == WDT_SEL_STOP);
    // locked part still uses the low three code bits on the oscillator
    assign use_per = sel[WDT_SRC_BIT] && !lock_reg;
    assign exp_bits = use_per ? 5'(WDT_PER_EXP_BASE + int'(sel[2:0]))
                              : 5'(WDT_OSC_EXP_BASE + int'(sel[2:0]));
    assign overflow = tick && !stopped &&
                      (count_reg == (WDT_CNT_W'(1) << exp_bits) - WDT_CNT_W'(1));

    wdt_tick_sel u_tick (
        .i_ref_clk  (i_ref_clk),
        .i_rst      (i_rst),
        .i_osc_tick (i_osc_tick),
        .i_per_tick (i_per_tick),
        .i_use_per  (use_per),
        .o_tick     (tick)
    );

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            count_reg <= '0;
        end else if (bus.wr_key && bus.wdata == WDT_KEY_VALUE) begin
            count_reg <= '0;
        end else if (overflow) begin
            count_reg <= '0;
        end else if (tick && !stopped) begin
            count_reg <= count_reg + WDT_CNT_W'(1);
        end
    end

    // outputs are sticky until system reset; the reset controller clears us
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            reset_reg  <= 1'b0;
            nmi_reg    <= 1'b0;
            osc_sw_reg <= 1'b0;
        end else if (overflow) begin
            if (mode_reg[WDT_MODE_HI_BIT]) begin
                if (stab_q2) begin
                    osc_sw_reg <= 1'b1;
                end else begin
                    reset_reg <= 1'b1;
                end
            end else if (mode_reg[WDT_MODE_LO_BIT]) begin
                nmi_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_reg <= 8'h00;
        end else if (bus.rd_mode) begin
            rdata_reg <= mode_reg;
        end else if (bus.rd_key) begin
            rdata_reg <= key_reg;
        end
    end

    assign bus.rdata       = rdata_reg;
    assign bus.reset_out   = reset_reg;
    assign bus.nmi_request = nmi_reg;
    assign bus.cpu_on_osc  = osc_sw_reg;
endmodule

//--- hdl/wdt_host.sv
// processor end: APB slave that issues byte accesses to the watchdog
`timescale 1ns/10ps
module wdt_host (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    wdt_if.host              link
);
    import wdt_pkg::*;

    wdt_host_state_t state_reg;
    logic [7:0]  mode_data_reg;
    logic [7:0]  key_data_reg;
    logic [3:0]  strobe_reg;
    logic [7:0]  last_rd_reg;
    logic        setup;

    assign setup = i_psel && !i_penable;

    // one cycle to issue, one to catch read data, then answer
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg  <= WDT_H_IDLE;
            strobe_reg <= 4'h0;
        end else begin
            strobe_reg <= 4'h0;
            case (state_reg)
                WDT_H_IDLE: begin
                    if (setup && i_pwrite && i_paddr == WDT_APB_CMD) begin
                        // mode accesses dropped while running from the oscillator
                        if (link.cpu_on_osc) begin
                            strobe_reg <= i_pwdata[3:0] &
                                          ~((4'(1) << WDT_CMD_MODE_WR) |
                                            (4'(1) << WDT_CMD_MODE_RD));
                        end else begin
                            strobe_reg <= i_pwdata[3:0];
                        end
                        state_reg  <= WDT_H_ACC;
                    end else if (setup) begin
                        state_reg <= WDT_H_DONE;
                    end
                end
                WDT_H_ACC:  state_reg <= WDT_H_DONE;
                WDT_H_DONE: state_reg <= WDT_H_IDLE;
                default:    state_reg <= WDT_H_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_data_reg <= WDT_MODE_STOPPED;
            key_data_reg  <= WDT_KEY_VALUE;
        end else if (setup && i_pwrite && i_paddr == WDT_APB_MODE) begin
            mode_data_reg <= i_pwdata[7:0];
        end else if (setup && i_pwrite && i_paddr == WDT_APB_KEY) begin
            key_data_reg <= i_pwdata[7:0];
        end
    end

    assign link.wr_mode = strobe_reg[WDT_CMD_MODE_WR];
    assign link.wr_key  = strobe_reg[WDT_CMD_KEY_WR];
    assign link.rd_mode = strobe_reg[WDT_CMD_MODE_RD];
    assign link.rd_key  = strobe_reg[WDT_CMD_KEY_RD];
    assign link.wdata   = strobe_reg[WDT_CMD_MODE_WR] ? mode_data_reg : key_data_reg;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            last_rd_reg <= 8'h00;
        end else if (state_reg == WDT_H_DONE) begin
            last_rd_reg <= link.rdata;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= (state_reg == WDT_H_DONE);
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            if (state_reg == WDT_H_DONE) begin
                case (i_paddr)
                    WDT_APB_MODE:   o_prdata <= {24'h000000, mode_data_reg};
                    WDT_APB_KEY:    o_prdata <= {24'h000000, link.rdata};
                    WDT_APB_STATUS: o_prdata <= {21'h0, link.cpu_on_osc,
                                                 link.nmi_request, link.reset_out,
                                                 last_rd_reg};
                    WDT_APB_CMD:    o_prdata <= 32'h0000_0000;
                    default:        o_pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule

//--- testbench/wdt_props.sv
// checker: assertions on the link between the processor end and the watchdog end
`timescale 1ns/10ps
module wdt_props (
    input wire logic       i_ref_clk,
    input wire logic       i_rst,
    input wire logic       wr_mode,
    input wire logic       wr_key,
    input wire logic       rd_mode,
    input wire logic       rd_key,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       reset_out,
    input wire logic       nmi_request,
    input wire logic       cpu_on_osc
);
    import wdt_pkg::*;
    logic [7:0] mode_m;
    logic       mode_done;
    logic       key_done;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    // shadow of the write-once mode byte, first write wins
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_m    <= WDT_MODE_RESET;
            mode_done <= 1'b0;
            key_done  <= 1'b0;
        end else begin
            if (wr_mode && !mode_done) begin
                mode_m    <= wdata;
                mode_done <= 1'b1;
            end
            if (wr_key) begin
                key_done <= 1'b1;
            end
        end
    end
    sequence s_quiet;
        (!reset_out && !nmi_request) [*6];
    endsequence
    sequence s_kick;
        wr_key && wdata == WDT_KEY_VALUE && !reset_out && !nmi_request;
    endsequence
    chk_start_quiet: assert property ($fell(i_rst) |-> s_quiet)
        else $error("action right after reset");
    chk_kick_quiet: assert property (s_kick |-> ##2 s_quiet)
        else $error("action right after key");
    chk_mode_read: assert property (rd_mode |=> rdata == mode_m)
        else $error("mode readback wrong");
    chk_key_read: assert property (rd_key && !key_done |=> rdata == WDT_KEY_RESET)
        else $error("key readback wrong");
    chk_reset_mode: assert property ($rose(reset_out) |-> mode_m[WDT_MODE_HI_BIT])
        else $error("reset in wrong mode");
    chk_nmi_mode: assert property ($rose(nmi_request) |->
        !mode_m[WDT_MODE_HI_BIT] && mode_m[WDT_MODE_LO_BIT]) else $error("nmi in wrong mode");
    chk_stop_holds: assert property (mode_done && mode_m[4:0] == WDT_SEL_STOP |->
        !reset_out && !nmi_request) else $error("stopped unit acted");
    chk_reset_held: assert property (reset_out |=> reset_out)
        else $error("reset output dropped");
    chk_nmi_held: assert property (nmi_request |=> nmi_request)
        else $error("nmi request dropped");
    chk_osc_switch: assert property ($rose(cpu_on_osc) |->
        (mode_m[WDT_MODE_HI_BIT] && !reset_out) [*4]) else $error("reset in stabilisation");
endmodule

//--- testbench/wdt_bench.sv
// testbench: both watchdog ends joined, driven over APB
`timescale 1ns/10ps
module wdt_bench;
    import wdt_pkg::*;
    logic        i_ref_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        osc_tick = 1'b1;
    logic        per_tick = 1'b1;
    logic        clock_lock = 1'b0;
    logic        osc_stab = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] q;
    logic        slv;
    int          errors = 0;
    int          compares = 0;
    wdt_if bus_if ();
    wire logic [2:0] acts = {bus_if.cpu_on_osc, bus_if.nmi_request, bus_if.reset_out};
    wdt_device i_wdt_device (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_osc_tick(osc_tick),
        .i_per_tick(per_tick), .i_option_clock_lock(clock_lock),
        .i_osc_stabilizing(osc_stab), .bus(bus_if.device));
    wdt_host i_wdt_host (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .link(bus_if.host));
    wdt_props i_wdt_props (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .wr_mode(bus_if.wr_mode),
        .wr_key(bus_if.wr_key), .rd_mode(bus_if.rd_mode), .rd_key(bus_if.rd_key),
        .wdata(bus_if.wdata), .rdata(bus_if.rdata), .reset_out(bus_if.reset_out),
        .nmi_request(bus_if.nmi_request), .cpu_on_osc(bus_if.cpu_on_osc));
    initial begin
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    task automatic conclude();
        if (errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one edge between transfers so psel is never assigned twice in a step
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            errors++;
            conclude();
        end
    endtask
    task automatic dev_wr(input int b, input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        xfer(1'b1, WDT_APB_CMD, 32'h1 << b);
    endtask
    // status low byte holds the byte last fetched from the watchdog end
    task automatic dev_rd(input int b);
        xfer(1'b1, WDT_APB_CMD, 32'h1 << b);
        xfer(1'b0, WDT_APB_STATUS, 32'h0);
    endtask
    // quiet until lo cycles, then only action k within hi cycles
    task automatic watch(input int k, input int lo, input int hi);
        int n;
        repeat (lo) @(posedge i_ref_clk);
        check({29'h0, acts}, 32'h0);
        for (n = lo; n < hi && acts[k] !== 1'b1; n++)
            @(posedge i_ref_clk);
        if (hi > lo) check({29'h0, acts}, 32'h1 << k);
    endtask
    task automatic start(input logic [7:0] mode);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        dev_wr(WDT_CMD_MODE_WR, WDT_APB_MODE, {24'h0, mode});
        dev_wr(WDT_CMD_KEY_WR, WDT_APB_KEY, {24'h0, WDT_KEY_VALUE});
    endtask
    initial begin
        repeat (16) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        dev_rd(WDT_CMD_MODE_RD);
        check(q, {24'h0, WDT_MODE_RESET});
        dev_rd(WDT_CMD_KEY_RD);
        check(q, {24'h0, WDT_KEY_RESET});
        xfer(1'b0, 8'h10, 32'h0);
        check({31'h0, slv}, 32'h1);
        start(8'h40);
        xfer(1'b0, WDT_APB_MODE, 32'h0);
        check(q, 32'h0000_0040);
        watch(0, 2000, 2000);
        dev_wr(WDT_CMD_KEY_WR, WDT_APB_KEY, 32'hAC);
        watch(0, 4000, 4200);
        start(8'h21);
        watch(1, 8100, 8300);
        osc_tick <= 1'b0;
        start(8'h48);
        watch(0, 65436, 65636);
        osc_tick <= 1'b1;
        clock_lock <= 1'b1;
        start(8'h48);
        watch(0, 4000, 4200);
        clock_lock <= 1'b0;
        start(WDT_MODE_STOPPED);
        dev_wr(WDT_CMD_MODE_WR, WDT_APB_MODE, 32'h40);
        dev_rd(WDT_CMD_MODE_RD);
        check(q, 32'h1F);
        watch(0, 4500, 4500);
        osc_stab <= 1'b1;
        start(8'h40);
        watch(2, 4000, 4200);
        dev_rd(WDT_CMD_MODE_RD);
        check(q, 32'h0000_0400);
        conclude();
    end
endmodule
